// ---- hdl/can_irq_line.sv ----
// one interrupt request line combining two sources with their enables
// assumes the request bit write strobe comes from logic on clk
`timescale 1ns/10ps
module can_irq_line (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [1:0] srcFlag,
  input wire logic [1:0] srcEnable,
  input wire logic irWriteZero,
  output logic irq
);
  logic [2:0] holdCnt_q;
  logic live;
  assign live = |(srcFlag & srcEnable);
  // software clear only masks for a fixed time; not a latch
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      holdCnt_q <= 3'h0;
    end else if (irWriteZero && live) begin
      holdCnt_q <= can_wti_pkg::IR_LOW_LAST + 3'h1;
    end else if (holdCnt_q != 3'h0) begin
      holdCnt_q <= holdCnt_q - 3'h1;
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq <= 1'b0;
    end else begin
      irq <= live && !(irWriteZero && live) && (holdCnt_q <= 3'h1);
    end
  end
endmodule : can_irq_line

// ---- hdl/can_sync2.sv ----
// two-stage synchroniser for a pin input
// assumes the pin is asynchronous to clk; resets to recessive
`timescale 1ns/10ps
module can_sync2 (
  input wire logic clk,
  input wire logic resetn,
  input wire logic din,
  output logic dout
);
  logic meta_q;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_q <= can_wti_pkg::RECESSIVE;
      dout <= can_wti_pkg::RECESSIVE;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule : can_sync2

// ---- hdl/can_wakeup_test_modes_irq.sv ----
// wakeup, test-mode pin routing and interrupt flag logic of the CAN controller
// assumes the protocol engine drives engineTx and consumes engineRx on clk;
// the caller keeps clk running while sleep is active
`timescale 1ns/10ps
module can_wakeup_test_modes_irq #(
  parameter int NUM_MBX = can_wti_pkg::NUM_MAILBOX,
  parameter int NUM_ERR = 8
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic can_rx_pin,
  output logic can_tx_pin,
  input wire logic can_pin_enable,
  input wire logic test_mode_select_hi,
  input wire logic test_mode_select_lo,
  input wire logic reqReset,
  input wire logic reqHalt,
  input wire logic reqOper,
  input wire logic reqSleep,
  input wire logic cancelSleep,
  input wire logic engineTx,
  output logic engineRx,
  output logic selfAck,
  output logic txStartAllow,
  input wire logic rxFifoStoreEarly,
  input wire logic rxFifoStoreLate,
  input wire logic txFifoDoneEarly,
  input wire logic txFifoDoneLate,
  input wire logic [15:0] mailbox_int_enable_reg,
  input wire logic [NUM_MBX-1:0] fresh_message_flag,
  input wire logic [NUM_MBX-1:0] sent_message_flag,
  input wire logic [NUM_ERR-1:0] fault_source_flags,
  input wire logic [NUM_ERR-1:0] fault_int_enable_reg,
  input wire logic [NUM_MBX-1:0] mbxIntEnable,
  input wire logic [5:0] can_int_enable_reg,
  input wire logic [5:0] statusRead,
  input wire logic [5:0] statusWriteZero,
  input wire logic [2:0] irWriteZero,
  output logic [2:0] int_request_bit,
  output logic [5:0] can_int_status_reg,
  output logic [3:0] modeState,
  output logic [1:0] testMode
);
  // status bit order: 0 rx done, 1 rx queue, 2 tx done, 3 tx queue, 4 fault, 5 wake
  localparam int S_RXD = 0;
  localparam int S_RXQ = 1;
  localparam int S_TXD = 2;
  localparam int S_TXQ = 3;
  localparam int S_FLT = 4;
  localparam int S_WAK = 5;

  can_wti_pkg::can_mode_t mode_q;
  can_wti_pkg::can_mode_t preSleep_q;
  can_wti_pkg::test_mode_t test_q;
  logic rxSync;
  logic rxPrev_q;
  logic fallEdge;
  logic rxInternal;
  logic [5:0] flags_q;
  logic [5:0] readOne_q;
  logic enterReset;
  logic active;

  can_sync2 u_rx_sync (
    .clk(clk),
    .resetn(resetn),
    .din(can_rx_pin),
    .dout(rxSync)
  );

  assign active = (mode_q != can_wti_pkg::MODE_SLEEP);
  assign enterReset = reqReset && (mode_q != can_wti_pkg::MODE_RESET) && active;

  // mode sequencing; sleep is entered only from reset or halt
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mode_q <= can_wti_pkg::MODE_RESET;
      preSleep_q <= can_wti_pkg::MODE_RESET;
    end else if (mode_q == can_wti_pkg::MODE_SLEEP) begin
      if (cancelSleep) begin
        mode_q <= preSleep_q;
      end
    end else if (reqSleep && (mode_q != can_wti_pkg::MODE_OPER)) begin
      preSleep_q <= mode_q;
      mode_q <= can_wti_pkg::MODE_SLEEP;
    end else if (reqReset) begin
      mode_q <= can_wti_pkg::MODE_RESET;
    end else if (reqHalt) begin
      mode_q <= can_wti_pkg::MODE_HALT;
    end else if (reqOper) begin
      mode_q <= can_wti_pkg::MODE_OPER;
    end
  end

  // test mode latches only in halt; software is expected to respect this too
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      test_q <= can_wti_pkg::TEST_OFF;
    end else if (mode_q == can_wti_pkg::MODE_HALT) begin
      test_q <= can_wti_pkg::test_mode_t'({test_mode_select_hi, test_mode_select_lo});
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rxPrev_q <= can_wti_pkg::RECESSIVE;
    end else begin
      rxPrev_q <= rxSync;
    end
  end
  // edge watch works in sleep too so a bus frame can wake the module
  assign fallEdge = rxPrev_q && !rxSync && can_pin_enable;

  // receive path: internal loop ignores the pin; listen-only ORs own dominant in
  always_comb begin
    unique case (test_q)
      can_wti_pkg::TEST_INT_LOOP: rxInternal = engineTx;
      can_wti_pkg::TEST_LISTEN: rxInternal = rxSync & engineTx;
      can_wti_pkg::TEST_EXT_LOOP: rxInternal = rxSync;
      can_wti_pkg::TEST_OFF: rxInternal = rxSync;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      can_tx_pin <= can_wti_pkg::RECESSIVE;
      engineRx <= can_wti_pkg::RECESSIVE;
      selfAck <= 1'b0;
      txStartAllow <= 1'b0;
    end else begin
      if (!active || !can_pin_enable) begin
        can_tx_pin <= can_wti_pkg::RECESSIVE;
      end else if (test_q == can_wti_pkg::TEST_LISTEN || test_q == can_wti_pkg::TEST_INT_LOOP) begin
        can_tx_pin <= can_wti_pkg::RECESSIVE;
      end else begin
        can_tx_pin <= engineTx;
      end
      engineRx <= active ? rxInternal : can_wti_pkg::RECESSIVE;
      selfAck <= active && (test_q == can_wti_pkg::TEST_EXT_LOOP ||
                            test_q == can_wti_pkg::TEST_INT_LOOP);
      txStartAllow <= active && (test_q != can_wti_pkg::TEST_LISTEN);
    end
  end

  // read-one tracking: a write of zero clears only after a read showed one
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      readOne_q <= 6'h00;
    end else begin
      readOne_q <= (readOne_q | (statusRead & flags_q)) & ~statusWriteZero;
    end
  end

  logic [5:0] setEv;
  logic [5:0] clrEv;
  logic rxDoneLive;
  logic txDoneLive;
  assign rxDoneLive = |(fresh_message_flag & mbxIntEnable);
  assign txDoneLive = |(sent_message_flag & mbxIntEnable);
  always_comb begin
    setEv = 6'h00;
    clrEv = 6'h00;
    if (active) begin
      setEv[S_RXQ] = mailbox_int_enable_reg[can_wti_pkg::MBX_RX_QUEUE_FLAG_EN_BIT] &&
        (mailbox_int_enable_reg[can_wti_pkg::MBX_RX_QUEUE_FLAG_TIMING_BIT] ?
         rxFifoStoreLate : rxFifoStoreEarly);
      setEv[S_TXQ] = mailbox_int_enable_reg[can_wti_pkg::MBX_TX_QUEUE_FLAG_EN_BIT] &&
        (mailbox_int_enable_reg[can_wti_pkg::MBX_TX_QUEUE_FLAG_TIMING_BIT] ?
         txFifoDoneLate : txFifoDoneEarly);
      setEv[S_FLT] = |(fault_source_flags & fault_int_enable_reg);
    end
    setEv[S_WAK] = fallEdge;
    // software clears of all but the wake flag are ignored while asleep, so the frozen flags stay as they were
    clrEv = active ? (readOne_q & statusWriteZero) : 6'h00;
    if (enterReset) begin
      clrEv = clrEv | 6'h1F;
    end
    clrEv[S_WAK] = readOne_q[S_WAK] & statusWriteZero[S_WAK];
  end

  // set wins over a software clear in the same cycle; reset-mode entry wins over all except on the wake flag
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      flags_q <= 6'h00;
    end else begin
      for (int i = 0; i < 6; i++) begin
        if (i == S_RXD) begin
          flags_q[i] <= enterReset ? 1'b0 : (active ? rxDoneLive : flags_q[i]);
        end else if (i == S_TXD) begin
          flags_q[i] <= enterReset ? 1'b0 : (active ? txDoneLive : flags_q[i]);
        end else if (enterReset && i != S_WAK) begin
          flags_q[i] <= 1'b0;
        end else if (setEv[i]) begin
          flags_q[i] <= 1'b1;
        end else if (clrEv[i]) begin
          flags_q[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      can_int_status_reg <= 6'h00;
      modeState <= can_wti_pkg::MODE_RESET;
      testMode <= can_wti_pkg::TEST_OFF;
    end else begin
      can_int_status_reg <= flags_q;
      modeState <= mode_q;
      testMode <= test_q;
    end
  end

  // pairing: line 0 rx done+rx queue, line 1 tx done+tx queue, line 2 fault+wake
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_irq
      can_irq_line u_line (
        .clk(clk),
        .resetn(resetn),
        .srcFlag(flags_q[2*g+1:2*g]),
        .srcEnable(can_int_enable_reg[2*g+1:2*g]),
        .irWriteZero(irWriteZero[g]),
        .irq(int_request_bit[g])
      );
    end
  endgenerate

  // checks restate the rules from ports and flags together with the active, enterReset, fallEdge and rxDoneLive/txDoneLive decode terms
  a_ir_live: assert property (@(posedge clk) disable iff (!resetn)
    (|(flags_q[1:0] & can_int_enable_reg[1:0]) == 1'b0) |=> !int_request_bit[0])
    else $error("rx request high without enabled source");
  a_ir1_live: assert property (@(posedge clk) disable iff (!resetn)
    (|(flags_q[3:2] & can_int_enable_reg[3:2]) == 1'b0) |=> !int_request_bit[1])
    else $error("tx request high without enabled source");
  a_ir2_live: assert property (@(posedge clk) disable iff (!resetn)
    (|(flags_q[5:4] & can_int_enable_reg[5:4]) == 1'b0) |=> !int_request_bit[2])
    else $error("fault request high without enabled source");

  sequence s_irclr;
    irWriteZero[0] && |(flags_q[1:0] & can_int_enable_reg[1:0]);
  endsequence
  sequence s_ir0live;
    !irWriteZero[0] && |(flags_q[1:0] & can_int_enable_reg[1:0]);
  endsequence
  a_ir_hold: assert property (@(posedge clk) disable iff (!resetn)
    s_irclr |=> !int_request_bit[0] [*5])
    else $error("request returned before five cycles");
  a_ir_back: assert property (@(posedge clk) disable iff (!resetn)
    s_irclr ##1 s_ir0live [*5] |=> int_request_bit[0])
    else $error("request did not return after the mask");

  a_int_tx: assert property (@(posedge clk) disable iff (!resetn)
    (test_q == can_wti_pkg::TEST_INT_LOOP) |=> can_tx_pin)
    else $error("tx pin dominant in internal loop");
  a_int_rx: assert property (@(posedge clk) disable iff (!resetn)
    (active && test_q == can_wti_pkg::TEST_INT_LOOP) |=> engineRx == $past(engineTx))
    else $error("internal loop did not feed tx to rx");
  a_ext_tx: assert property (@(posedge clk) disable iff (!resetn)
    (active && can_pin_enable && test_q == can_wti_pkg::TEST_EXT_LOOP)
      |=> can_tx_pin == $past(engineTx))
    else $error("external loop did not drive the pin");
  a_ack_loop: assert property (@(posedge clk) disable iff (!resetn)
    (active && (test_q == can_wti_pkg::TEST_EXT_LOOP ||
                test_q == can_wti_pkg::TEST_INT_LOOP)) |=> selfAck)
    else $error("no own acknowledge in loop-back");
  a_listen_tx: assert property (@(posedge clk) disable iff (!resetn)
    (test_q == can_wti_pkg::TEST_LISTEN) |=> can_tx_pin && !txStartAllow)
    else $error("listen-only drove bus or allowed start");
  a_listen_rx: assert property (@(posedge clk) disable iff (!resetn)
    (active && test_q == can_wti_pkg::TEST_LISTEN && !engineTx) |=> !engineRx)
    else $error("listen-only lost its own dominant bit");
  a_test_hold: assert property (@(posedge clk) disable iff (!resetn)
    (mode_q != can_wti_pkg::MODE_HALT) |=> $stable(test_q))
    else $error("test mode changed outside halt");

  a_wake_set: assert property (@(posedge clk) disable iff (!resetn)
    fallEdge |=> flags_q[S_WAK])
    else $error("wake flag not set on falling edge");
  a_wake_quiet: assert property (@(posedge clk) disable iff (!resetn)
    (!fallEdge && !flags_q[S_WAK]) |=> !flags_q[S_WAK])
    else $error("wake flag set without an edge");
  a_sleep_ret: assert property (@(posedge clk) disable iff (!resetn)
    (mode_q == can_wti_pkg::MODE_SLEEP && cancelSleep) |=> mode_q == $past(preSleep_q))
    else $error("sleep exit went to wrong mode");
  a_sleep_entry: assert property (@(posedge clk) disable iff (!resetn)
    (reqSleep && (mode_q == can_wti_pkg::MODE_RESET || mode_q == can_wti_pkg::MODE_HALT))
      |=> mode_q == can_wti_pkg::MODE_SLEEP && preSleep_q == $past(mode_q))
    else $error("sleep entry lost the prior mode");
  a_sleep_tx: assert property (@(posedge clk) disable iff (!resetn)
    !active |=> can_tx_pin)
    else $error("tx pin dominant in sleep");
  a_sleep_frz: assert property (@(posedge clk) disable iff (!resetn)
    !active |=> $stable(flags_q[4:0]))
    else $error("flags changed in sleep");

  a_reset_clr: assert property (@(posedge clk) disable iff (!resetn)
    enterReset |=> flags_q[4:0] == 5'h00)
    else $error("flags survived reset mode entry");
  a_fault_set: assert property (@(posedge clk) disable iff (!resetn)
    (active && |(fault_source_flags & fault_int_enable_reg) && !enterReset)
      |=> flags_q[S_FLT])
    else $error("fault flag not set");
  a_rxq_set: assert property (@(posedge clk) disable iff (!resetn)
    (active && !enterReset && mailbox_int_enable_reg[can_wti_pkg::MBX_RX_QUEUE_FLAG_EN_BIT] &&
      (mailbox_int_enable_reg[can_wti_pkg::MBX_RX_QUEUE_FLAG_TIMING_BIT] ?
       rxFifoStoreLate : rxFifoStoreEarly)) |=> flags_q[S_RXQ])
    else $error("rx queue flag not set");
  a_rxq_quiet: assert property (@(posedge clk) disable iff (!resetn)
    (!mailbox_int_enable_reg[can_wti_pkg::MBX_RX_QUEUE_FLAG_EN_BIT] && !flags_q[S_RXQ])
      |=> !flags_q[S_RXQ])
    else $error("rx queue flag set while disabled");
  a_txq_set: assert property (@(posedge clk) disable iff (!resetn)
    (active && !enterReset && mailbox_int_enable_reg[can_wti_pkg::MBX_TX_QUEUE_FLAG_EN_BIT] &&
      (mailbox_int_enable_reg[can_wti_pkg::MBX_TX_QUEUE_FLAG_TIMING_BIT] ?
       txFifoDoneLate : txFifoDoneEarly)) |=> flags_q[S_TXQ])
    else $error("tx queue flag not set");
  a_txq_quiet: assert property (@(posedge clk) disable iff (!resetn)
    (!mailbox_int_enable_reg[can_wti_pkg::MBX_TX_QUEUE_FLAG_EN_BIT] && !flags_q[S_TXQ])
      |=> !flags_q[S_TXQ])
    else $error("tx queue flag set while disabled");
  a_rxdone: assert property (@(posedge clk) disable iff (!resetn)
    (active && !enterReset) |=> flags_q[S_RXD] == $past(rxDoneLive))
    else $error("rx done does not follow enabled mailboxes");
  a_txdone: assert property (@(posedge clk) disable iff (!resetn)
    (active && !enterReset) |=> flags_q[S_TXD] == $past(txDoneLive))
    else $error("tx done does not follow enabled mailboxes");
endmodule : can_wakeup_test_modes_irq

// ---- hdl/can_wti_pkg.sv ----
// constants shared by the wakeup, test-mode and interrupt logic
// assumes a single 250 MHz module clock, kept running by the caller in sleep
package can_wti_pkg;
  typedef enum logic [1:0] {
    TEST_OFF = 2'h0,
    TEST_LISTEN = 2'h1,
    TEST_EXT_LOOP = 2'h2,
    TEST_INT_LOOP = 2'h3
  } test_mode_t;
  typedef enum logic [3:0] {
    MODE_OPER = 4'h1,
    MODE_RESET = 4'h2,
    MODE_HALT = 4'h4,
    MODE_SLEEP = 4'h8
  } can_mode_t;
  localparam int CLK_MHZ = 250;
  localparam int IR_LOW_CYCLES = 5;
  localparam logic [2:0] IR_LOW_LAST = 3'(IR_LOW_CYCLES - 1);
  localparam int MBX_RX_QUEUE_FLAG_TIMING_BIT = 13;
  localparam int MBX_RX_QUEUE_FLAG_EN_BIT = 12;
  localparam int MBX_TX_QUEUE_FLAG_TIMING_BIT = 9;
  localparam int MBX_TX_QUEUE_FLAG_EN_BIT = 8;
  localparam int NUM_MAILBOX = 16;
  localparam logic [1:0] FLAGS_RESET = 2'h0;
  localparam logic RECESSIVE = 1'b1;
endpackage : can_wti_pkg

// ---- verification/can_bus_node.sv ----
// far side of the pin pair: transceiver plus other nodes, as a wired-AND bus
// assumes the bench commands a dominant level from another node through dominantReq
`timescale 1ns/10ps
module can_bus_node (
  input wire logic txPin,
  input wire logic dominantReq,
  output logic rxPin
);
  // idle bus is pulled recessive, any dominant driver wins
  assign rxPin = txPin & ~dominantReq;
endmodule : can_bus_node

// ---- verification/tb_top.sv ----
// self-checking bench for the wakeup, test-mode and interrupt logic
// assumes one 250 MHz clock that keeps running, also in sleep
`timescale 1ns/10ps
module tb_top;
  logic clk = 0, resetn = 0, rxPin, txPin, pinEn = 1, tHi = 0, tLo = 0, dom = 0, eTx = 1;
  logic rRst = 0, rHalt = 0, rOper = 0, rSleep = 0, cSleep = 0;
  logic rfE = 0, rfL = 0, tfE = 0, tfL = 0, eRx, sAck, txOk;
  logic [15:0] mie = 0, fresh = 0, sent = 0, mbxEn = 0;
  logic [7:0] fSrc = 0, fEn = 0;
  logic [5:0] ie = 0, sRd = 0, sWz = 0, st;
  logic [2:0] irWz = 0, irq;
  logic [3:0] mode;
  logic [1:0] tm;
  int err_count = 0, n_checks = 0, cyc = 0;
  always #2 clk = ~clk;
  can_bus_node bus (.txPin(txPin), .dominantReq(dom), .rxPin(rxPin));
  can_wakeup_test_modes_irq dut (.clk(clk), .resetn(resetn), .can_rx_pin(rxPin),
    .can_tx_pin(txPin), .can_pin_enable(pinEn), .test_mode_select_hi(tHi),
    .test_mode_select_lo(tLo), .reqReset(rRst), .reqHalt(rHalt), .reqOper(rOper),
    .reqSleep(rSleep), .cancelSleep(cSleep), .engineTx(eTx), .engineRx(eRx),
    .selfAck(sAck), .txStartAllow(txOk), .rxFifoStoreEarly(rfE), .rxFifoStoreLate(rfL),
    .txFifoDoneEarly(tfE), .txFifoDoneLate(tfL), .mailbox_int_enable_reg(mie),
    .fresh_message_flag(fresh), .sent_message_flag(sent), .fault_source_flags(fSrc),
    .fault_int_enable_reg(fEn), .mbxIntEnable(mbxEn), .can_int_enable_reg(ie),
    .statusRead(sRd), .statusWriteZero(sWz), .irWriteZero(irWz),
    .int_request_bit(irq), .can_int_status_reg(st), .modeState(mode), .testMode(tm));
  task end_of_test;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_of_test
  task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  // mode requests are one-cycle pulses: 0 reset, 1 halt, 2 oper, 3 sleep, 4 cancel sleep
  task req(input int k);
    case (k)
      0: rRst = 1;
      1: rHalt = 1;
      2: rOper = 1;
      3: rSleep = 1;
      default: cSleep = 1;
    endcase
    step(1);
    {rRst, rHalt, rOper, rSleep, cSleep} = 5'h00;
    step(3);
  endtask : req
  // a clear only counts after the bit has been read as one
  task clr(input int b);
    sRd[b] = 1;
    step(1);
    sRd = 6'h00;
    sWz[b] = 1;
    step(1);
    sWz = 6'h00;
    step(3);
  endtask : clr
  task t_reset;
    chk("tx", 16'(txPin), 16'h0001);
    chk("mode", 16'(mode), 16'h0002);
    chk("irq", 16'(irq), 16'h0000);
    chk("status", 16'(st), 16'h0000);
  endtask : t_reset
  task t_modes;
    req(1);
    chk("halt", 16'(mode), 16'h0004);
    for (int i = 0; i < 4; i++) begin
      {tHi, tLo} = 2'(i);
      eTx = 1'b0;
      step(5);
      chk("test", 16'(tm), 16'(i));
      if (i == 1) chk("listen tx", 16'(txPin), 16'h0001);
      if (i == 1) chk("listen start", 16'(txOk), 16'h0000);
      if (i == 1) chk("listen rx", 16'(eRx), 16'h0000);
      if (i == 2) chk("ext tx", 16'(txPin), 16'h0000);
      if (i == 2) chk("ext rx", 16'(eRx), 16'h0000);
      chk("ack", 16'(sAck), 16'(i >= 2));
      if (i == 3) chk("int tx", 16'(txPin), 16'h0001);
      if (i == 3) chk("int rx", 16'(eRx), 16'h0000);
      eTx = 1'b1;
      dom = 1'b1;
      step(5);
      if (i == 3) chk("pin ignored", 16'(eRx), 16'h0001);
      dom = 1'b0;
    end
    {tHi, tLo} = 2'h0;
    step(3);
    req(2);
    {tHi, tLo} = 2'h3;
    step(4);
    chk("test locked", 16'(tm), 16'h0000);
    {tHi, tLo} = 2'h0;
  endtask : t_modes
  task t_irq;
    // the pin toggling in the test-mode pass has set the wake flag outside sleep
    chk("wake ext", 16'(st[5]), 16'h0001);
    clr(5);
    mie = 16'h1100;
    ie = 6'h1A;
    {rfE, rfL, tfE, tfL} = 4'hF;
    fSrc = 8'h04;
    fEn = 8'h04;
    step(1);
    {rfE, rfL, tfE, tfL} = 4'h0;
    fSrc = 8'h00;
    step(3);
    chk("flags", 16'(st), 16'h001A);
    chk("irq", 16'(irq), 16'h0007);
    irWz[0] = 1;
    step(1);
    irWz = 3'h0;
    for (int c = 0; c < 5; c++) begin
      chk("ir masked", 16'(irq[0]), 16'h0000);
      step(1);
    end
    chk("ir back", 16'(irq[0]), 16'h0001);
    ie = 6'h00;
    step(3);
    chk("irq off", 16'(irq), 16'h0000);
    chk("kept", 16'(st), 16'h001A);
    ie = 6'h1A;
    sWz[1] = 1;
    step(1);
    sWz = 6'h00;
    step(3);
    chk("no read", 16'(st[1]), 16'h0001);
    clr(1);
    chk("cleared", 16'(st), 16'h0018);
    chk("line0", 16'(irq[0]), 16'h0000);
    mie = 16'h0000;
    {rfE, rfL} = 2'h3;
    step(1);
    {rfE, rfL} = 2'h0;
    step(3);
    chk("rxq off", 16'(st[1]), 16'h0000);
    clr(3);
    mie = 16'h3300;
    {rfE, tfE} = 2'h3;
    step(1);
    {rfE, tfE} = 2'h0;
    step(3);
    chk("fifo early", 16'(st[3:1]), 16'h0000);
    {rfL, tfL} = 2'h3;
    step(1);
    {rfL, tfL} = 2'h0;
    step(3);
    chk("fifo late", 16'(st[3:1]), 16'h0005);
    req(0);
    chk("reset mode", 16'(st), 16'h0000);
  endtask : t_irq
  task t_done;
    ie = 6'h05;
    fresh = 16'h0008;
    sent = 16'h0008;
    step(4);
    chk("not enabled", 16'(st), 16'h0000);
    mbxEn = 16'h0008;
    step(4);
    chk("done", 16'(st), 16'h0005);
    chk("line0 1", 16'(irq[1:0]), 16'h0003);
    clr(2);
    chk("read only", 16'(st[2]), 16'h0001);
    fresh = 16'h0000;
    sent = 16'h0000;
    step(4);
    chk("done clear", 16'(st), 16'h0000);
  endtask : t_done
  task t_wake;
    req(3);
    req(4);
    chk("back reset", 16'(mode), 16'h0002);
    ie = 6'h20;
    pinEn = 1'b1;
    req(1);
    req(3);
    chk("sleep", 16'(mode), 16'h0008);
    dom = 1'b1;
    step(6);
    chk("wake", 16'(st[5]), 16'h0001);
    chk("wake irq", 16'(irq), 16'h0004);
    dom = 1'b0;
    req(4);
    chk("back halt", 16'(mode), 16'h0004);
    clr(5);
    chk("wake clr", 16'(st[5]), 16'h0000);
    dom = 1'b1;
    step(6);
    dom = 1'b0;
    chk("wake awake", 16'(st[5]), 16'h0001);
  endtask : t_wake
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      end_of_test();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    #1;
    resetn = 1;
    step(2);
    t_reset();
    t_modes();
    t_irq();
    t_done();
    t_wake();
    end_of_test();
  end
endmodule : tb_top
